// *** common/lamp_defs.svh ***
// Constants for the power status lamps and the fault code flasher
`ifndef LAMP_DEFS_SVH
`define LAMP_DEFS_SVH

// --------------------------------------------------------------
// Time base
// --------------------------------------------------------------
`define LAMP_CLK_MHZ 250
`define LAMP_HALF_SEC_MS 500
`define LAMP_HALF_SEC_CYC (`LAMP_HALF_SEC_MS * 1000 * `LAMP_CLK_MHZ)

// --------------------------------------------------------------
// Frame timing in half-second ticks
// --------------------------------------------------------------
`define LAMP_START_TICKS 3'd4
`define LAMP_ONE_TICKS 3'd2
`define LAMP_ZERO_TICKS 3'd1
`define LAMP_GAP_TICKS 3'd1
`define LAMP_LAST_BIT 3'd7
`define LAMP_SINGLE_TICKS 1

// --------------------------------------------------------------
// Fault sources (upper nibble) and condition codes
// --------------------------------------------------------------
`define SRC_DC_IN 4'h1
`define SRC_EXT_FIRST 4'h7
`define SRC_EXT_LAST 4'he
`define LAMP_NUM_FAULTS 29
`define FC_ADP_OV 8'h10
`define FC_REPL_OV 8'h11
`define FC_DC_OC 8'h12
`define FC_DC_NOLOAD 8'h13
`define FC_DC_SENSE 8'h14
`define FC_MB_CHG_OC 8'h21
`define FC_MB_DIS_NOLOAD 8'h22
`define FC_MB_CHG_NODIR 8'h23
`define FC_MB_SENSE 8'h24
`define FC_MB_CHG_OFF 8'h25
`define FC_SB_CHG_OC 8'h31
`define FC_SB_DIS_NOLOAD 8'h32
`define FC_SB_CHG_NODIR 8'h33
`define FC_SB_SENSE 8'h34
`define FC_SB_CHG_OFF 8'h35
`define FC_SBY_LOW 8'h40
`define FC_SBY_LOW_NOCHG 8'h45
`define FC_C1_OV 8'h50
`define FC_C1_UV_ON 8'h51
`define FC_C1_UV_BOOT 8'h52
`define FC_C1_UV_SUSP 8'h53
`define FC_C1_BAD_OFF 8'h54
`define FC_C1_UV_PWRON 8'h55
`define FC_C2_OV 8'h60
`define FC_C2_UV_ON 8'h61
`define FC_C2_UV_BOOT 8'h62
`define FC_C2_UV_SUSP 8'h63
`define FC_C2_BAD_OFF 8'h64
`define FC_C2_UV_PWRON 8'h65

`endif

// *** common/lamp_pkg.sv ***
// Types shared by the lamp controller and its tick generator
package lamp_pkg;
`include "lamp_defs.svh"

   typedef logic [7:0] code_t;
   typedef logic [`LAMP_NUM_FAULTS-1:0] fault_vec_t;

   // Gray coded along idle, start, bit, gap, bit ...
   typedef enum logic [1:0] {
      FR_IDLE  = 2'b00,
      FR_START = 2'b01,
      FR_BIT   = 2'b11,
      FR_GAP   = 2'b10
   } frame_state_t;

   typedef struct packed {
      logic rst_meta;
      logic rst_n;
   } rst_state_t;

   typedef struct packed {
      logic fault_active;
      code_t code;
      frame_state_t frame;
      logic [2:0] bit_idx;
      logic [2:0] ticks_left;
      logic restart;
      logic sys_on_prev;
      logic single_arm;
      logic single_on;
      logic blink_phase;
      logic batt_orange;
      logic batt_green;
      logic dc_orange;
      logic dc_green;
   } ctrl_state_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } presc_state_t;
endpackage

// *** common/lamp_tick_if.sv ***
// Half-second tick link between lamp controller and prescaler
`timescale 1ns/1ps
interface lamp_tick_if;
   logic tick;
   logic restart;

   modport ctrl (
      input tick,
      output restart
   );
   modport gen (
      output tick,
      input restart
   );
endinterface

// *** rtl/lamp_tick_gen.sv ***
// Prescaler that turns the system clock into half-second ticks
`timescale 1ns/1ps
`include "lamp_defs.svh"
module lamp_tick_gen #(
   parameter int unsigned HALF_SEC_CYCLES = `LAMP_HALF_SEC_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   lamp_tick_if.gen tk
);
   import lamp_pkg::*;

   presc_state_t s_q;
   presc_state_t s_d;

   // ------------------------------------------------------------
   // Counter: restart realigns the tick grid to a frame start
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (tk.restart) begin
         s_d.cnt = 32'h0;
      end else if (s_q.cnt == 32'(HALF_SEC_CYCLES - 1)) begin
         s_d.cnt = 32'h0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 32'h1;
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tk.tick = s_q.tick;
endmodule

// *** rtl/power_status_fault_code_indicator.sv ***
// Battery and DC-input status lamps with serial fault code flasher
// What this block does
// - Battery lamp orange: charging with DC present
// - Battery lamp green: full with DC present
// - Battery lamp blinks orange: on, low
// - One orange flash at battery-only low switch-on
// - Lamps dark when no condition applies
// - DC lamp green: adapter power, no fault
// - Fault makes DC lamp flash the code orange
// - Frame: off two seconds, eight bits
// - Zero bit: lamp on half a second
// - Half second off between bits
// - Code sent least significant bit first
// - Upper nibble names the faulty source rail
// - Codes 10h, 11h: input overvoltage
// - Codes 12h-14h: input current faults
// - Codes 21h-25h: main battery current faults
// - Codes 31h-35h: second battery faults
// - Codes 40h, 45h: standby rail low
// - Codes 50h-55h: first core rail faults
// - Codes 60h-65h: second core rail faults
`timescale 1ns/1ps
`include "lamp_defs.svh"
module power_status_fault_code_indicator #(
   parameter int unsigned HALF_SEC_CYCLES = `LAMP_HALF_SEC_CYC
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   input wire logic I_DC_PRESENT,
   input wire logic I_BATT_PRESENT,
   input wire logic I_BATT_CHARGING,
   input wire logic I_BATT_FULL,
   input wire logic I_BATT_LOW,
   input wire logic I_SYS_ON,
   input wire lamp_pkg::fault_vec_t I_FAULT_FLAGS,
   input wire logic I_EXT_FAULT_VALID,
   input wire lamp_pkg::code_t I_EXT_FAULT_CODE,
   output logic O_BATT_ORANGE,
   output logic O_BATT_GREEN,
   output logic O_DC_ORANGE,
   output logic O_DC_GREEN,
   output logic O_FAULT_ACTIVE,
   output lamp_pkg::code_t O_FAULT_CODE
);
   import lamp_pkg::*;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------

   // Code reported for each fault flag position
   function automatic code_t code_of(input logic [4:0] idx);
      code_t c;
      c = 8'h00;
      case (idx)
         5'd0: c = `FC_ADP_OV;
         5'd1: c = `FC_REPL_OV;
         5'd2: c = `FC_DC_OC;
         5'd3: c = `FC_DC_NOLOAD;
         5'd4: c = `FC_DC_SENSE;
         5'd5: c = `FC_MB_CHG_OC;
         5'd6: c = `FC_MB_DIS_NOLOAD;
         5'd7: c = `FC_MB_CHG_NODIR;
         5'd8: c = `FC_MB_SENSE;
         5'd9: c = `FC_MB_CHG_OFF;
         5'd10: c = `FC_SB_CHG_OC;
         5'd11: c = `FC_SB_DIS_NOLOAD;
         5'd12: c = `FC_SB_CHG_NODIR;
         5'd13: c = `FC_SB_SENSE;
         5'd14: c = `FC_SB_CHG_OFF;
         5'd15: c = `FC_SBY_LOW;
         5'd16: c = `FC_SBY_LOW_NOCHG;
         5'd17: c = `FC_C1_OV;
         5'd18: c = `FC_C1_UV_ON;
         5'd19: c = `FC_C1_UV_BOOT;
         5'd20: c = `FC_C1_UV_SUSP;
         5'd21: c = `FC_C1_BAD_OFF;
         5'd22: c = `FC_C1_UV_PWRON;
         5'd23: c = `FC_C2_OV;
         5'd24: c = `FC_C2_UV_ON;
         5'd25: c = `FC_C2_UV_BOOT;
         5'd26: c = `FC_C2_UV_SUSP;
         5'd27: c = `FC_C2_BAD_OFF;
         5'd28: c = `FC_C2_UV_PWRON;
         default: c = 8'h00;
      endcase
      return c;
   endfunction

   // Lowest flag wins; external rails only if nibble 7..E
   function automatic logic [8:0] pick_fault(
      input fault_vec_t flags,
      input logic ext_valid,
      input code_t ext_code
   );
      logic [8:0] r;
      r = 9'h000;
      if (ext_valid && ext_code[7:4] >= `SRC_EXT_FIRST &&
          ext_code[7:4] <= `SRC_EXT_LAST) begin
         r = {1'b1, ext_code};
      end
      for (int i = `LAMP_NUM_FAULTS - 1; i >= 0; i--) begin
         if (flags[i]) begin
            r = {1'b1, code_of(5'(i))};
         end
      end
      return r;
   endfunction

   // Lit time of one code bit, in half-second ticks
   function automatic logic [2:0] bit_ticks(input logic b);
      logic [2:0] t;
      t = b ? `LAMP_ONE_TICKS : `LAMP_ZERO_TICKS;
      return t;
   endfunction

   // One tick less, held at zero so a stray tick cannot wrap
   function automatic logic [2:0] tick_down(input logic [2:0] t);
      logic [2:0] r;
      r = (t == 3'd0) ? 3'd0 : t - 3'd1;
      return r;
   endfunction

   // True on the tick that ends the current period
   function automatic logic period_ends(input logic [2:0] t);
      logic e;
      e = t == 3'd1;
      return e;
   endfunction

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   rst_state_t r_q;
   logic rst_n;

   // Async assert, release through two flops
   // so every flop leaves reset on one clean edge
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         r_q <= '0;
      end else begin
         r_q <= '{rst_meta: 1'b1, rst_n: r_q.rst_meta};
      end
   end

   assign rst_n = r_q.rst_n;

   // ------------------------------------------------------------
   // Half-second time base
   // ------------------------------------------------------------
   lamp_tick_if tk_bus ();

   // Restart pulls the tick grid onto the first frame start after idle
   lamp_tick_gen #(
      .HALF_SEC_CYCLES(HALF_SEC_CYCLES)
   ) u_tick (
      .i_clk(I_SYS_CLK),
      .i_rst_n(rst_n),
      .tk(tk_bus.gen)
   );

   // ------------------------------------------------------------
   // Controller state
   // ------------------------------------------------------------
   ctrl_state_t s_q;
   ctrl_state_t s_d;
   logic tick;
   logic [8:0] cand;
   logic power_gone;
   logic switch_on;
   logic [2:0] next_idx;

   assign tick = tk_bus.tick;
   assign tk_bus.restart = s_q.restart;

   // ------------------------------------------------------------
   // Helper signals
   // ------------------------------------------------------------

   // Fault candidate, lowest flag first
   always_comb begin
      cand = pick_fault(I_FAULT_FLAGS, I_EXT_FAULT_VALID,
                        I_EXT_FAULT_CODE);
   end

   // Power events seen this cycle
   always_comb begin
      power_gone = !I_DC_PRESENT && !I_BATT_PRESENT;
      switch_on = I_SYS_ON && !s_q.sys_on_prev;
   end

   // Code bit that follows the current one
   always_comb begin
      next_idx = s_q.bit_idx + 3'd1;
   end

   // Next state of everything
   always_comb begin
      s_d = s_q;
      s_d.restart = 1'b0;
      s_d.sys_on_prev = I_SYS_ON;

      // --------------------------------------------------------
      // Fault latch
      // --------------------------------------------------------
      // First code held, later faults ignored.
      // Losing both sources clears it, but a fault seen in that
      // same cycle still gets latched.
      if (!s_q.fault_active) begin
         if (cand[8]) begin
            s_d.fault_active = 1'b1;
            s_d.code = cand[7:0];
         end
      end else if (power_gone) begin
         s_d.fault_active = cand[8];
         s_d.code = cand[8] ? cand[7:0] : 8'h00;
      end

      // --------------------------------------------------------
      // Frame sequencer
      // --------------------------------------------------------
      // Four dark ticks open a frame; a one is lit two ticks, a
      // zero one tick, one dark tick between bits. Bit 7 runs
      // straight into the next dark start, so the frame repeats
      // while the fault stands with no extra gap.
      case (s_q.frame)
         FR_IDLE: begin
            if (s_q.fault_active) begin
               s_d.frame = FR_START;
               s_d.ticks_left = `LAMP_START_TICKS;
               s_d.restart = 1'b1;
            end
         end
         FR_START: begin
            if (tick) begin
               if (period_ends(s_q.ticks_left)) begin
                  s_d.frame = FR_BIT;
                  s_d.bit_idx = 3'd0;
                  s_d.ticks_left = bit_ticks(s_q.code[0]);
               end else begin
                  s_d.ticks_left = tick_down(s_q.ticks_left);
               end
            end
         end
         FR_BIT: begin
            if (tick) begin
               if (!period_ends(s_q.ticks_left)) begin
                  s_d.ticks_left = tick_down(s_q.ticks_left);
               end else if (s_q.bit_idx == `LAMP_LAST_BIT) begin
                  s_d.frame = FR_START;
                  s_d.ticks_left = `LAMP_START_TICKS;
               end else begin
                  s_d.frame = FR_GAP;
                  s_d.ticks_left = `LAMP_GAP_TICKS;
               end
            end
         end
         FR_GAP: begin
            if (tick) begin
               if (period_ends(s_q.ticks_left)) begin
                  s_d.frame = FR_BIT;
                  s_d.bit_idx = next_idx;
                  s_d.ticks_left = bit_ticks(s_q.code[next_idx]);
               end else begin
                  s_d.ticks_left = tick_down(s_q.ticks_left);
               end
            end
         end
         default: begin
            s_d.frame = FR_IDLE;
         end
      endcase

      // Cleared fault drops the frame at once
      if (!s_q.fault_active) begin
         if (s_q.frame != FR_IDLE) begin
            s_d.frame = FR_IDLE;
            s_d.bit_idx = 3'd0;
            s_d.ticks_left = 3'd0;
         end
      end

      // --------------------------------------------------------
      // Battery timing
      // --------------------------------------------------------
      // Even blink phase, one tick on and one tick off
      if (tick) begin
         s_d.blink_phase = !s_q.blink_phase;
      end

      // Single switch-on flash: armed now, lit for one whole
      // tick so it is never a sliver of a half second
      if (tick) begin
         s_d.single_on = s_q.single_arm;
         s_d.single_arm = 1'b0;
      end
      if (switch_on && !I_DC_PRESENT && I_BATT_LOW) begin
         s_d.single_arm = 1'b1;
      end

      // --------------------------------------------------------
      // Lamp colours
      // --------------------------------------------------------
      // Battery lamp, charge states take priority
      s_d.batt_orange = 1'b0;
      s_d.batt_green = 1'b0;
      if (I_DC_PRESENT && I_BATT_FULL) begin
         s_d.batt_green = 1'b1;
      end else if (I_DC_PRESENT && I_BATT_CHARGING) begin
         s_d.batt_orange = 1'b1;
      end else if (s_q.single_arm || s_q.single_on) begin
         s_d.batt_orange = s_q.single_on;
      end else if (I_SYS_ON && I_BATT_LOW) begin
         s_d.batt_orange = s_q.blink_phase;
      end

      // DC lamp: fault flashing overrides the green state
      s_d.dc_orange = 1'b0;
      s_d.dc_green = 1'b0;
      if (s_q.fault_active) begin
         s_d.dc_orange = s_q.frame == FR_BIT;
      end else if (I_DC_PRESENT) begin
         s_d.dc_green = 1'b1;
      end
   end

   // State register
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all straight from flops
   // ------------------------------------------------------------
   assign O_BATT_ORANGE = s_q.batt_orange;
   assign O_BATT_GREEN = s_q.batt_green;
   assign O_DC_ORANGE = s_q.dc_orange;
   assign O_DC_GREEN = s_q.dc_green;
   assign O_FAULT_ACTIVE = s_q.fault_active;
   assign O_FAULT_CODE = s_q.code;
endmodule

// *** verif/lamp_asserts.sv ***
// Port-level checks for the status lamps and the fault code flasher
`timescale 1ns/1ps
module lamp_asserts #(
   parameter int unsigned HALF_SEC_CYCLES = 8
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   input wire logic I_DC_PRESENT,
   input wire logic I_BATT_PRESENT,
   input wire logic I_BATT_CHARGING,
   input wire logic I_BATT_FULL,
   input wire lamp_pkg::fault_vec_t I_FAULT_FLAGS,
   input wire logic I_EXT_FAULT_VALID,
   input wire lamp_pkg::code_t I_EXT_FAULT_CODE,
   input wire logic O_BATT_ORANGE,
   input wire logic O_BATT_GREEN,
   input wire logic O_DC_ORANGE,
   input wire logic O_DC_GREEN,
   input wire logic O_FAULT_ACTIVE,
   input wire lamp_pkg::code_t O_FAULT_CODE
);
   import lamp_pkg::*;
   localparam int unsigned T = HALF_SEC_CYCLES;
   logic [3:0] live_q;
   logic [31:0] on_q;
   logic [31:0] off_q;
   logic ext_ok;
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   // Margin covers the two-flop reset release inside the block
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         live_q <= 4'h0;
         on_q <= 32'h0;
         off_q <= 32'h0;
      end else begin
         live_q <= {live_q[2:0], 1'b1};
         on_q <= O_DC_ORANGE ? on_q + 32'h1 : 32'h0;
         off_q <= O_DC_ORANGE ? 32'h0 : off_q + 32'h1;
      end
   end
   assign ext_ok = I_EXT_FAULT_VALID
      && (I_EXT_FAULT_CODE[7:4] inside {[4'h7:4'he]});
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!live_q[3]);
   sequence s_dark_start;
      (!O_DC_ORANGE)[*8];
   endsequence
   property p_green;
      I_DC_PRESENT && I_BATT_FULL |=> O_BATT_GREEN && !O_BATT_ORANGE;
   endproperty
   a_green: assert property (p_green)
      else $error("battery not green");
   property p_orange;
      I_DC_PRESENT && I_BATT_CHARGING && !I_BATT_FULL
         |=> O_BATT_ORANGE && !O_BATT_GREEN;
   endproperty
   a_orange: assert property (p_orange)
      else $error("battery not orange");
   property p_dc_green;
      I_DC_PRESENT && !O_FAULT_ACTIVE |=> O_DC_GREEN;
   endproperty
   a_dc_green: assert property (p_dc_green)
      else $error("dc not green");
   property p_low_wins;
      !O_FAULT_ACTIVE && I_FAULT_FLAGS[0] |=> O_FAULT_CODE == 8'h10;
   endproperty
   a_low_wins: assert property (p_low_wins)
      else $error("code not 10h");
   property p_hold;
      O_FAULT_ACTIVE && (I_DC_PRESENT || I_BATT_PRESENT)
         |=> O_FAULT_ACTIVE && $stable(O_FAULT_CODE);
   endproperty
   a_hold: assert property (p_hold)
      else $error("latched code lost");
   property p_clear;
      !I_DC_PRESENT && !I_BATT_PRESENT && I_FAULT_FLAGS == '0
         && !I_EXT_FAULT_VALID |=> !O_FAULT_ACTIVE && O_FAULT_CODE == 8'h00;
   endproperty
   a_clear: assert property (p_clear)
      else $error("fault not cleared");
   property p_ext;
      !O_FAULT_ACTIVE && I_FAULT_FLAGS == '0 && ext_ok
         |=> O_FAULT_CODE == $past(I_EXT_FAULT_CODE);
   endproperty
   a_ext: assert property (p_ext)
      else $error("rail code not taken");
   property p_dark;
      (!O_FAULT_ACTIVE)[*2] |=> !O_DC_ORANGE;
   endproperty
   a_dark: assert property (p_dark)
      else $error("dc orange without fault");
   property p_start;
      $rose(O_FAULT_ACTIVE) |-> s_dark_start;
   endproperty
   a_start: assert property (p_start)
      else $error("frame not opened dark");
   property p_on_len;
      $fell(O_DC_ORANGE) && O_FAULT_ACTIVE |-> on_q == T || on_q == 2 * T;
   endproperty
   a_on_len: assert property (p_on_len)
      else $error("bad lit length");
   property p_off_len;
      $rose(O_DC_ORANGE) |-> off_q == T || off_q >= 4 * T;
   endproperty
   a_off_len: assert property (p_off_len)
      else $error("bad dark length");
endmodule

// *** verif/lamp_reader.sv ***
// Technician model that reads the fault code off the DC-input lamp
`timescale 1ns/1ps
module lamp_reader #(
   parameter int unsigned HALF_SEC_CYCLES = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_lamp,
   output logic [7:0] o_code,
   output logic o_done,
   output logic o_bad
);
   localparam int unsigned T = HALF_SEC_CYCLES;
   logic lvl_q;
   logic [31:0] len_q;
   logic [2:0] n_q;
   // ------------------------------------------------------------
   // Run-length decoder
   // ------------------------------------------------------------
   // Held in reset while no fault is latched, so a cut frame is no error
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lvl_q <= 1'b0;
         len_q <= 32'h0;
         n_q <= 3'h0;
         o_code <= 8'h00;
         o_done <= 1'b0;
         o_bad <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_lamp == lvl_q) begin
            len_q <= len_q + 32'h1;
         end else begin
            lvl_q <= i_lamp;
            len_q <= 32'h1;
            if (lvl_q) begin
               o_code <= {len_q == 2 * T, o_code[7:1]};
               o_bad <= o_bad | (len_q != T && len_q != 2 * T);
               o_done <= n_q == 3'h7;
               n_q <= n_q + 3'h1;
            end else if (len_q >= 4 * T) begin
               n_q <= 3'h0;
            end else begin
               o_bad <= o_bad | (len_q != T);
            end
         end
      end
   end
endmodule

// *** verif/power_status_fault_code_indicator_tb.sv ***
// Bench for the status lamps and fault code flasher
`timescale 1ns/1ps
module power_status_fault_code_indicator_tb;
   import lamp_pkg::*;
   localparam int unsigned HALF_SEC_CYCLES = 8;
   localparam int T = HALF_SEC_CYCLES;
   localparam code_t FC [29] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
      8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h31, 8'h32, 8'h33, 8'h34,
      8'h35, 8'h40, 8'h45, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
      8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
   logic clk, rstn, dc_in, batt_in, chg, full, low, sys_on, ext_v;
   logic batt_or, batt_gr, dc_or, dc_gr, f_act, rd_done, rd_bad;
   fault_vec_t flags;
   code_t ext_c, f_code;
   logic [7:0] rd_code;
   int n_mismatch, total_checks, i, c;
   // ------------------------------------------------------------
   // Block, lamp reader, clock
   // ------------------------------------------------------------
   power_status_fault_code_indicator #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES))
   power_status_fault_code_indicator_inst (.I_SYS_CLK(clk), .I_RSTN(rstn),
      .I_DC_PRESENT(dc_in), .I_BATT_PRESENT(batt_in),
      .I_BATT_CHARGING(chg), .I_BATT_FULL(full), .I_BATT_LOW(low),
      .I_SYS_ON(sys_on), .I_FAULT_FLAGS(flags), .I_EXT_FAULT_VALID(ext_v),
      .I_EXT_FAULT_CODE(ext_c), .O_BATT_ORANGE(batt_or),
      .O_BATT_GREEN(batt_gr), .O_DC_ORANGE(dc_or), .O_DC_GREEN(dc_gr),
      .O_FAULT_ACTIVE(f_act), .O_FAULT_CODE(f_code));
   lamp_reader #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) lamp_reader_inst (
      .i_clk(clk), .i_rst_n(rstn & f_act), .i_lamp(dc_or),
      .o_code(rd_code), .o_done(rd_done), .o_bad(rd_bad));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic count_or(input int n, output int cnt);
      cnt = 0;
      repeat (n) begin
         @(negedge clk);
         cnt += int'(batt_or === 1'b1);
      end
   endtask
   // Bounded wait for one whole frame read off the lamp
   task automatic wait_frame(input code_t exp);
      int k;
      for (k = 0; k < 600; k++) begin
         @(negedge clk);
         if (rd_done === 1'b1) break;
      end
      chk(rd_done, 1'b1);
      chk(rd_code, exp);
      chk(rd_bad, 1'b0);
   endtask
   // Latch a fault, try to overwrite it, read two frames, then clear
   task automatic run_fault(input fault_vec_t fl, input logic v,
      input code_t cd, input logic act, input code_t exp);
      @(posedge clk);
      flags <= fl;
      ext_v <= v;
      ext_c <= cd;
      @(posedge clk);
      // Rival flags only once latched, so a refused code stays clear
      flags <= act ? ~fl : '0;
      ext_v <= 1'b0;
      @(posedge clk);
      flags <= '0;
      @(negedge clk);
      chk(f_act, act);
      chk(f_code, exp);
      if (act) begin
         wait_frame(exp);
         wait_frame(exp);
         chk(dc_gr, 1'b0);
      end
      @(posedge clk);
      dc_in <= 1'b0;
      batt_in <= 1'b0;
      @(posedge clk);
      dc_in <= 1'b1;
      batt_in <= 1'b1;
      cyc(3);
      @(negedge clk);
      chk({f_act, dc_or, f_code}, 32'h0);
      chk(dc_gr, 1'b1);
   endtask
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog: a few times the expected run length
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {rstn, dc_in, batt_in, chg, full, low, sys_on, ext_v} = 8'h00;
      flags = '0;
      ext_c = 8'h00;
      cyc(16);
      @(negedge clk);
      chk({batt_or, batt_gr, dc_or, dc_gr, f_act, f_code}, 32'h0);
      @(posedge clk);
      rstn <= 1'b1;
      batt_in <= 1'b1;
      cyc(4);
      // Steady colours over every mix of DC, charge, full, power
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         {dc_in, chg, full, sys_on} <= 4'(i);
         cyc(3);
         @(negedge clk);
         chk(batt_gr, i[3] & i[1]);
         chk(batt_or, i[3] & i[2] & ~i[1]);
         chk(dc_gr, i[3]);
      end
      @(posedge clk);
      {dc_in, chg, full, sys_on} <= 4'h0;
      cyc(3);
      @(posedge clk);
      sys_on <= 1'b1;
      low <= 1'b1;
      @(posedge clk);
      low <= 1'b0;
      count_or(4 * T, c);
      chk(c, T);
      @(posedge clk);
      low <= 1'b1;
      cyc(2 * T);
      count_or(8 * T, c);
      chk(c, 4 * T);
      @(posedge clk);
      {low, sys_on, dc_in} <= 3'b001;
      cyc(3);
      run_fault(29'h000000a, 1'b0, 8'h00, 1'b1, 8'h11);
      run_fault(29'h0000004, 1'b1, 8'h7a, 1'b1, 8'h12);
      for (i = 0; i < 29; i++) begin
         run_fault(fault_vec_t'(1) << i, 1'b0, 8'h00, 1'b1,
            FC[i]);
      end
      run_fault('0, 1'b1, 8'h7a, 1'b1, 8'h7a);
      run_fault('0, 1'b1, 8'he5, 1'b1, 8'he5);
      run_fault('0, 1'b1, 8'hf3, 1'b0, 8'h00);
      run_fault('0, 1'b1, 8'h2a, 1'b0, 8'h00);
      give_verdict();
   end
endmodule
bind power_status_fault_code_indicator lamp_asserts #(
   .HALF_SEC_CYCLES(HALF_SEC_CYCLES)) lamp_asserts_inst (
   .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_DC_PRESENT(I_DC_PRESENT),
   .I_BATT_PRESENT(I_BATT_PRESENT), .I_BATT_CHARGING(I_BATT_CHARGING),
   .I_BATT_FULL(I_BATT_FULL), .I_FAULT_FLAGS(I_FAULT_FLAGS),
   .I_EXT_FAULT_VALID(I_EXT_FAULT_VALID),
   .I_EXT_FAULT_CODE(I_EXT_FAULT_CODE), .O_BATT_ORANGE(O_BATT_ORANGE),
   .O_BATT_GREEN(O_BATT_GREEN), .O_DC_ORANGE(O_DC_ORANGE),
   .O_DC_GREEN(O_DC_GREEN), .O_FAULT_ACTIVE(O_FAULT_ACTIVE),
   .O_FAULT_CODE(O_FAULT_CODE));
